/* bench/far_side.sv */
// Charger, load and host side of the comparator levels
module far_side (
  input  wire logic        clk,
  output prot_pkg::sense_s sense
);
  timeunit 1ns;
  timeprecision 100ps;

  prot_pkg::sense_s s = prot_pkg::SENSE_RST;

  assign sense = s;

  ////////////////////////////////////////////////////////////////////////////
  // Moves just after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Host command pulses, two cycles low then two high
  task automatic ship(input int n);
    for (int i = 0; i < n; i++) begin
      s.ship_n = 1'b0;
      step(2);
      s.ship_n = 1'b1;
      step(2);
    end
  endtask

  // Momentary tie of load sense to ground
  task automatic gnd_tap();
    s.ls_gnd = 1'b1;
    step(4);
    s.ls_gnd = 1'b0;
  endtask
endmodule

/* bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic             clk   = 1'b0;
  logic             rst_n = 1'b0;
  prot_pkg::sense_s sense;
  logic             chg;
  logic             dsg;
  logic             pd;
  logic             ds;
  int               err_count   = 0;
  int               check_count = 0;

  // Shortened delays so every path fits in one run
  localparam int abn_cyc  = 40;
  localparam int ocur_cyc = 2000;
  localparam int odis_cyc = 80;
  localparam int pd_cyc   = 100;
  localparam int ship_cyc = 200;

  always #50 clk = ~clk;

  prot_fsm #(
    .TIOC_CYC  (abn_cyc),
    .TIOD_CYC  (ocur_cyc),
    .TVOD_CYC  (odis_cyc),
    .TPD_CYC   (pd_cyc),
    .TSHIP_CYC (ship_cyc)
  ) u_prot_fsm (
    .CORE_CLK   (clk),
    .RESET_N    (rst_n),
    .SENSE      (sense),
    .CHG_SW_ON  (chg),
    .DSG_SW_ON  (dsg),
    .POWER_DOWN (pd),
    .DEEP_SLEEP (ds)
  );

  far_side u_far_side (
    .clk   (clk),
    .sense (sense)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Outputs as {charge, discharge, power down, deep sleep}
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] mask = 4'hf);
    check_count++;
    if (({chg, dsg, pd, ds} & mask) !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, {chg, dsg, pd, ds} & mask);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_wake_gnd();
    step(20);
    chk("blocked", 4'h1);
    u_far_side.gnd_tap();
    step(2);
    chk("gnd wake", 4'hc);
  endtask

  task automatic t_abnormal();
    u_far_side.s.below_cha = 1'b1;
    step(30);
    chk("abn early", 4'hc);
    u_far_side.s.below_cha = 1'b0;
    step(1);
    u_far_side.s.below_cha = 1'b1;
    step(35);
    chk("abn cleared", 4'hc);
    step(15);
    chk("abn trip", 4'h4);
    u_far_side.s.below_cha = 1'b0;
    step(5);
    chk("abn release", 4'hc);
  endtask

  task automatic t_overcur();
    u_far_side.s.at_overcur = 1'b1;
    step(1990);
    chk("ocur early", 4'hc);
    step(20);
    chk("ocur trip", 4'h8);
    u_far_side.s.below_cha = 1'b1;
    step(60);
    chk("abn unarmed", 4'h8);
    u_far_side.s.below_cha = 1'b0;
    u_far_side.s.batt_low = 1'b1;
    step(95);
    chk("ocur pdown", 4'h2);
    u_far_side.s.at_overcur = 1'b0;
    u_far_side.s.far_supply = 1'b1;
    step(5);
    chk("pdown exit", 4'h8);
    u_far_side.s.below_cha = 1'b1;
    step(50);
    chk("abn in odis", 4'h0, 4'h8);
    u_far_side.s.below_cha = 1'b0;
    u_far_side.s.far_supply = 1'b0;
    u_far_side.s.batt_low = 1'b0;
    u_far_side.s.batt_ok = 1'b1;
    step(8);
    chk("odis release", 4'hc);
  endtask

  task automatic t_odis();
    u_far_side.s.batt_ok = 1'b0;
    u_far_side.s.batt_low = 1'b1;
    step(70);
    chk("odis early", 4'hc);
    step(20);
    chk("odis trip", 4'h8);
    step(85);
    chk("pdown early", 4'h8);
    step(20);
    chk("pdown", 4'h2);
    u_far_side.s.batt_low = 1'b0;
    u_far_side.s.batt_ok = 1'b1;
    u_far_side.s.far_supply = 1'b1;
    step(8);
    chk("pdown release", 4'hc);
    u_far_side.s.far_supply = 1'b0;
  endtask

  task automatic t_zero();
    u_far_side.s.batt_ok = 1'b0;
    u_far_side.s.batt_low = 1'b1;
    u_far_side.s.chg_v0 = 1'b1;
    u_far_side.s.below_cha = 1'b1;
    step(5);
    chk("zero entry", 4'h8);
    step(60);
    chk("zero wins", 4'h8);
    u_far_side.s.batt_low = 1'b0;
    u_far_side.s.batt_ok = 1'b1;
    step(5);
    chk("zero end", 4'hc);
    u_far_side.s.chg_v0 = 1'b0;
    u_far_side.s.below_cha = 1'b0;
  endtask

  task automatic t_short();
    u_far_side.s.at_overcur = 1'b1;
    u_far_side.s.at_short = 1'b1;
    step(1700);
    chk("short early", 4'hc);
    step(110);
    chk("short trip", 4'h8);
    u_far_side.s.at_short = 1'b0;
    u_far_side.s.at_overcur = 1'b0;
    step(5);
    chk("short release", 4'hc);
  endtask

  task automatic t_ship();
    u_far_side.ship(2);
    step(250);
    u_far_side.ship(1);
    step(20);
    chk("ship expired", 4'hc);
    step(250);
    u_far_side.ship(3);
    step(15);
    chk("ship sleep", 4'h1);
    u_far_side.s.at_short = 1'b1;
    u_far_side.s.far_supply = 1'b1;
    step(10);
    chk("wake refused", 4'h1);
    u_far_side.s.at_short = 1'b0;
    step(10);
    chk("charger wake", 4'hc);
    u_far_side.s.far_supply = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Sequence and watchdog
  initial begin
    step(6);
    chk("reset", 4'h1);
    rst_n = 1'b1;
    t_wake_gnd();
    t_abnormal();
    t_overcur();
    t_odis();
    t_zero();
    t_short();
    t_ship();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule

/* rtl/prot_fsm.sv */
// How it works
// - Low load-sense while charging trips charge path
// - Abnormal charge armed in normal with discharge on, or in over-discharge
// - Abnormal charge in over-discharge stops charging
// - Charger removal clears abnormal charge state
// - Zero-volt charging beats abnormal charge detection
// - Load short cuts discharge within short time
// - Load short released when sense falls again
// - Three low command pulses enter deep sleep
// - Charger wakes deep sleep if no fault
// - Load-sense tied to ground also wakes
// - Shared over-current timer starts on detect
// - Persisting over-current or short stops discharge
// - Low battery after over-current trip enters power-down
// - Zero-volt charger forces charge on, discharge off
// - Zero-volt charging ends at release voltage
// - Over-discharge waits fixed time then powers down
// - Charger leaves power-down with switch off
// - Charge overcurrent delay twelve milliseconds
// - Short switch-off 180 us, under 300
module prot_fsm #(
  parameter int TIOC_CYC  = prot_pkg::TIOC_CYC,
  parameter int TIOD_CYC  = prot_pkg::TIOD_CYC,
  parameter int TVOD_CYC  = prot_pkg::TVOD_CYC,
  parameter int TPD_CYC   = prot_pkg::TPD_CYC,
  parameter int TSHIP_CYC = prot_pkg::TSHIP_CYC
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RESET_N,
  input  wire prot_pkg::sense_s SENSE,
  output logic                  CHG_SW_ON,
  output logic                  DSG_SW_ON,
  output logic                  POWER_DOWN,
  output logic                  DEEP_SLEEP
);

  ////////////////////////////////////////////////////////////////////////////
  // Counter step with saturation
  function automatic prot_pkg::cnt_t step(input logic run, input prot_pkg::cnt_t cnt);
    step = run ? ((cnt == '1) ? cnt : cnt + 1'b1) : '0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  prot_pkg::sense_s s1_r;
  prot_pkg::sense_s s_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      s1_r <= prot_pkg::SENSE_RST;
      s_r  <= prot_pkg::SENSE_RST;
    end else begin
      s1_r <= SENSE;
      s_r  <= s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  prot_pkg::state_e state_r;
  prot_pkg::state_e state_nxt;
  prot_pkg::cnt_t   c_cnt_r;
  prot_pkg::cnt_t   o_cnt_r;
  prot_pkg::cnt_t   v_cnt_r;
  prot_pkg::cnt_t   p_cnt_r;
  prot_pkg::cnt_t   w_cnt_r;
  logic [1:0]       pulses_r;
  logic [1:0]       pulses_nxt;
  logic             ship_prev_r;
  logic             chg_nxt;
  logic             dsg_nxt;

  wire in_normal  = (state_r == prot_pkg::ST_NORMAL);
  wire in_odis    = (state_r == prot_pkg::ST_ODIS);
  wire in_ocur    = (state_r == prot_pkg::ST_OCUR);
  wire zv_cond    = s_r.chg_v0 && s_r.batt_low;
  wire wake_req   = s_r.far_supply || s_r.ls_gnd;
  wire fault_free = !s_r.at_short && !s_r.batt_low;

  ////////////////////////////////////////////////////////////////////////////
  // Fault and ship-window timers
  wire c_run = ((in_normal && DSG_SW_ON) || in_odis) && s_r.below_cha && !zv_cond;
  wire o_run = in_normal && s_r.at_overcur;
  wire v_run = (in_normal || in_ocur) && s_r.batt_low;
  wire p_run = in_odis && !s_r.batt_ok;
  wire w_run = (pulses_r != 2'h0);

  wire c_hit = c_run && (c_cnt_r >= prot_pkg::cnt_t'(TIOC_CYC - 1));
  wire s_hit = o_run && s_r.at_short
               && (o_cnt_r >= prot_pkg::cnt_t'(prot_pkg::TSHORT_CYC - 1));
  wire o_hit = o_run && (o_cnt_r >= prot_pkg::cnt_t'(TIOD_CYC - 1));
  wire v_hit = v_run && (v_cnt_r >= prot_pkg::cnt_t'(TVOD_CYC - 1));
  wire p_hit = p_run && (p_cnt_r >= prot_pkg::cnt_t'(TPD_CYC - 1));
  wire w_hit = w_run && (w_cnt_r >= prot_pkg::cnt_t'(TSHIP_CYC - 1));

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      c_cnt_r <= '0;
      o_cnt_r <= '0;
      v_cnt_r <= '0;
      p_cnt_r <= '0;
      w_cnt_r <= '0;
    end else begin
      c_cnt_r <= step(c_run, c_cnt_r);
      o_cnt_r <= step(o_run, o_cnt_r);
      v_cnt_r <= step(v_run, v_cnt_r);
      p_cnt_r <= step(p_run, p_cnt_r);
      w_cnt_r <= step(w_run && !w_hit, w_cnt_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ship-mode command pulses
  wire ship_rise = s_r.ship_n && !ship_prev_r;
  wire ship_done = ship_rise && (pulses_r == 2'(prot_pkg::SHIP_PULSES - 1));

  always_comb begin
    pulses_nxt = pulses_r;
    if (ship_done) begin
      pulses_nxt = 2'h0;
    end else if (w_hit) begin
      pulses_nxt = {1'b0, ship_rise};
    end else if (ship_rise) begin
      pulses_nxt = pulses_r + 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ship_prev_r <= 1'b1;
      pulses_r    <= 2'h0;
    end else begin
      ship_prev_r <= s_r.ship_n;
      pulses_r    <= pulses_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection state machine
  always_comb begin
    state_nxt = state_r;
    if (ship_done && state_r != prot_pkg::ST_SLEEP) begin
      state_nxt = prot_pkg::ST_SLEEP;
    end else begin
      case (state_r)
        prot_pkg::ST_NORMAL: begin
          if (s_hit) begin
            state_nxt = prot_pkg::ST_SHORT;
          end else if (o_hit) begin
            state_nxt = prot_pkg::ST_OCUR;
          end else if (c_hit) begin
            state_nxt = prot_pkg::ST_ABN;
          end else if (zv_cond) begin
            state_nxt = prot_pkg::ST_ZERO;
          end else if (v_hit) begin
            state_nxt = prot_pkg::ST_ODIS;
          end
        end
        prot_pkg::ST_ODIS: begin
          if (zv_cond) begin
            state_nxt = prot_pkg::ST_ZERO;
          end else if (c_hit) begin
            state_nxt = prot_pkg::ST_ABN;
          end else if (s_r.batt_ok) begin
            state_nxt = prot_pkg::ST_NORMAL;
          end else if (p_hit) begin
            state_nxt = prot_pkg::ST_PDOWN;
          end
        end
        prot_pkg::ST_PDOWN: begin
          if (s_r.far_supply) begin
            state_nxt = prot_pkg::ST_ODIS;
          end
        end
        prot_pkg::ST_OCUR: begin
          if (v_hit) begin
            state_nxt = prot_pkg::ST_PDOWN;
          end else if (!s_r.at_overcur) begin
            state_nxt = prot_pkg::ST_NORMAL;
          end
        end
        prot_pkg::ST_SHORT: begin
          if (!s_r.at_short) begin
            state_nxt = prot_pkg::ST_NORMAL;
          end
        end
        prot_pkg::ST_ABN: begin
          if (!s_r.below_cha) begin
            state_nxt = prot_pkg::ST_NORMAL;
          end
        end
        prot_pkg::ST_ZERO: begin
          if (s_r.batt_ok) begin
            state_nxt = prot_pkg::ST_NORMAL;
          end
        end
        prot_pkg::ST_SLEEP: begin
          if (wake_req && fault_free) begin
            state_nxt = prot_pkg::ST_NORMAL;
          end
        end
        default: begin
          state_nxt = prot_pkg::ST_SLEEP;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch outputs
  always_comb begin
    case (state_nxt)
      prot_pkg::ST_NORMAL: begin
        chg_nxt = 1'b1;
        dsg_nxt = 1'b1;
      end
      prot_pkg::ST_ABN: begin
        chg_nxt = 1'b0;
        dsg_nxt = 1'b1;
      end
      prot_pkg::ST_ODIS, prot_pkg::ST_OCUR, prot_pkg::ST_SHORT: begin
        chg_nxt = 1'b1;
        dsg_nxt = 1'b0;
      end
      prot_pkg::ST_ZERO: begin
        chg_nxt = 1'b1;
        dsg_nxt = 1'b0;
      end
      default: begin
        chg_nxt = 1'b0;
        dsg_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state_r    <= prot_pkg::ST_SLEEP;
      CHG_SW_ON  <= 1'b0;
      DSG_SW_ON  <= 1'b0;
      POWER_DOWN <= 1'b0;
      DEEP_SLEEP <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      CHG_SW_ON  <= chg_nxt;
      DSG_SW_ON  <= dsg_nxt;
      POWER_DOWN <= (state_nxt == prot_pkg::ST_PDOWN);
      DEEP_SLEEP <= (state_nxt == prot_pkg::ST_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  abn_trip_a: assert property (
    (in_normal && c_run && c_cnt_r == prot_pkg::cnt_t'(TIOC_CYC - 1) && !ship_done
     && !o_hit && !s_hit) |=> (state_r == prot_pkg::ST_ABN) && !CHG_SW_ON)
    else $error("abnormal charge did not open charge path");

  abn_arm_a: assert property (
    (in_normal && c_cnt_r != '0) |-> $past(DSG_SW_ON) && $past(s_r.below_cha))
    else $error("abnormal charge timer ran without discharge on");

  od_abn_a: assert property (
    (in_odis && c_hit && !zv_cond && !ship_done) |=> state_r == prot_pkg::ST_ABN)
    else $error("abnormal charge in over-discharge not caught");

  abn_clear_a: assert property (
    (state_r == prot_pkg::ST_ABN && !s_r.below_cha && !ship_done)
    |=> in_normal ##0 CHG_SW_ON)
    else $error("abnormal charge state not cleared");

  zv_prio_a: assert property (zv_cond |-> c_cnt_r == '0 || $past(!zv_cond))
    else $error("abnormal charge timer ran during zero-volt charge");

  // Age of a load short seen while discharging
  prot_pkg::cnt_t short_age_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      short_age_r <= '0;
    end else begin
      short_age_r <= step(in_normal && s_r.at_short && s_r.at_overcur, short_age_r);
    end
  end

  short_off_a: assert property (
    (short_age_r >= prot_pkg::cnt_t'(prot_pkg::TSHORT_CYC)) |-> !DSG_SW_ON)
    else $error("load short not cut within switch-off time");

  short_rel_a: assert property (
    (state_r == prot_pkg::ST_SHORT && !s_r.at_short && !ship_done) |=> in_normal)
    else $error("load short not released");

  ship_enter_a: assert property (
    ship_done |=> DEEP_SLEEP && !CHG_SW_ON && !DSG_SW_ON ##1 pulses_r == 2'h0)
    else $error("ship command did not enter deep sleep");

  wake_a: assert property (
    (state_r == prot_pkg::ST_SLEEP && wake_req && fault_free && !ship_done)
    |=> in_normal && DSG_SW_ON && !DEEP_SLEEP)
    else $error("deep sleep did not wake");

  oc_pd_a: assert property (
    (in_ocur && v_hit && !ship_done) |=> POWER_DOWN && !DSG_SW_ON)
    else $error("low battery after trip not powered down");

  zero_a: assert property (
    (state_r == prot_pkg::ST_ZERO) |-> CHG_SW_ON && !DSG_SW_ON)
    else $error("zero-volt charge switches wrong");

  odis_pd_a: assert property (
    (in_odis && p_hit && !zv_cond && !c_hit && !ship_done) |=> POWER_DOWN)
    else $error("over-discharge did not power down");

  cnt_clr_a: assert property ((!o_run) |=> o_cnt_r == '0)
    else $error("over-current timer not cleared");

  short_cov: cover property (in_normal ##1 state_r == prot_pkg::ST_SHORT);
  ship_cov:  cover property (ship_done ##1 DEEP_SLEEP);
  wake_cov:  cover property (DEEP_SLEEP ##1 in_normal);
  zero_cov:  cover property (state_r == prot_pkg::ST_ZERO ##1 in_normal);

endmodule

/* rtl/prot_pkg.sv */
package prot_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS      = 100;
  localparam int T_IOC_US    = 12000;
  localparam int T_IOD_US    = 10000;
  localparam int T_VOD_US    = 80000;
  localparam int T_SHORT_US  = 180;
  localparam int T_PD_MS     = 1500;
  localparam int T_SHIP_US   = 100000;
  localparam int TIOC_CYC    = T_IOC_US * 1000 / CLK_NS;
  localparam int TIOD_CYC    = T_IOD_US * 1000 / CLK_NS;
  localparam int TVOD_CYC    = T_VOD_US * 1000 / CLK_NS;
  localparam int TSHORT_CYC  = T_SHORT_US * 1000 / CLK_NS;
  localparam int TPD_CYC     = T_PD_MS * 1000000 / CLK_NS;
  localparam int TSHIP_CYC   = T_SHIP_US * 1000 / CLK_NS;
  localparam int CNT_W       = 24;
  localparam int SHIP_PULSES = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [CNT_W-1:0] cnt_t;

  typedef enum logic [7:0] {
    ST_NORMAL = 8'h01,
    ST_ODIS   = 8'h02,
    ST_PDOWN  = 8'h04,
    ST_OCUR   = 8'h08,
    ST_SHORT  = 8'h10,
    ST_ABN    = 8'h20,
    ST_ZERO   = 8'h40,
    ST_SLEEP  = 8'h80
  } state_e;

  typedef struct packed {
    logic below_cha;
    logic at_overcur;
    logic at_short;
    logic batt_low;
    logic batt_ok;
    logic chg_v0;
    logic far_supply;
    logic ls_gnd;
    logic ship_n;
  } sense_s;

  localparam sense_s SENSE_RST = 9'h001;

endpackage
